// ### rtl/zdc_cfg.svh
// Purpose: Constants for the zero-delay clock mode control block.
// Assumes: Included by the package and the design by its bare name.
// Notes: Offsets are byte addresses of 32-bit registers.
`ifndef ZDC_CFG_SVH
`define ZDC_CFG_SVH

// Widths of the internal counters, the event fields and the register port.
`define ZDC_PW 16
`define ZDC_GW 8
`define ZDC_AW 8
`define ZDC_DW 32
`define ZDC_EVW 3

// Register byte offsets.
`define ZDC_OFS_CTRL 8'h00
`define ZDC_OFS_STATUS 8'h04
`define ZDC_OFS_IRQ_STAT 8'h08
`define ZDC_OFS_IRQ_MASK 8'h0c

// Mode select codes.
`define ZDC_SEL_OFF 2'h0
`define ZDC_SEL_RSVD 2'h1
`define ZDC_SEL_BYPASS 2'h2
`define ZDC_SEL_PLL 2'h3

// Event bit positions in the status and mask registers.
`define ZDC_EV_LOCK 0
`define ZDC_EV_LOSS 1
`define ZDC_EV_RSVD 2

// Control bit: write one to restart acquisition.
`define ZDC_CTRL_RESTART 0

// Status field positions.
`define ZDC_ST_LOCK 0
`define ZDC_ST_FSM 1
`define ZDC_ST_SEL 3
`define ZDC_ST_RANGE 5
`define ZDC_ST_DBL 6

// Reset values and defaults of the loop model.
`define ZDC_MASK_RST 3'h0
`define ZDC_LOCK_REFS 16
`define ZDC_WIN 2
`define ZDC_LO_HMIN 16'h0004
`define ZDC_LO_HMAX 16'h00ff
`define ZDC_HI_HMIN 16'h0001
`define ZDC_HI_HMAX 16'h0003
`define ZDC_NOUT 10

`endif

// ### rtl/zdc_pkg.sv
// Purpose: Types for the zero-delay clock mode control block.
// Assumes: zdc_cfg.svh gives the widths.
// Notes: One packed struct holds all block state.
`include "zdc_cfg.svh"

package zdc_pkg;

    // Loop state, Gray coded along off, acquire, locked.
    typedef enum logic [1:0] {
        ZDC_OFF = 2'h0,
        ZDC_ACQ = 2'h1,
        ZDC_LOCK = 2'h3
    } zdc_fsm_t;

    typedef struct packed {
        zdc_fsm_t st;
        logic [1:0] sel;
        logic range;
        logic dbl;
        logic ref_q;
        logic fb_q;
        logic [`ZDC_PW-1:0] per_cnt;
        logic [`ZDC_PW-1:0] per;
        logic [`ZDC_PW-1:0] ph_cnt;
        logic [`ZDC_PW-1:0] gen_cnt;
        logic gen_clk;
        logic adv;
        logic ret;
        logic aligned;
        logic [`ZDC_GW-1:0] good;
        logic q;
        logic oe;
        logic lock;
        logic [`ZDC_EVW-1:0] stat;
        logic [`ZDC_EVW-1:0] mask;
        logic [`ZDC_DW-1:0] rdata;
    } zdc_state_t;

endpackage

// ### rtl/zdc_mode_ctrl.sv
// What this block does
// - Lock output high once loop is locked.
// - Lock output low while loop still acquiring.
// - Select code sets tri-state, bypass or loop.
// - Range input picks the output frequency band.
// - Double input runs outputs at twice reference in loop mode.
// - Unconnected range and double inputs read low.
// - Longer feedback delay moves outputs earlier.
//
// Purpose: Mode, frequency and lock control of a zero-delay buffer.
// Assumes: All inputs synchronous to clk; straps held static.
// Notes: The loop is a digital model in clk cycles, not analog.
`timescale 1ns/1ps
`default_nettype none
`include "zdc_cfg.svh"

module zdc_mode_ctrl
    import zdc_pkg::*;
#(
    parameter int NOUT = `ZDC_NOUT,
    parameter logic [`ZDC_GW-1:0] LOCK_REFS = `ZDC_GW'(`ZDC_LOCK_REFS),
    parameter logic [`ZDC_PW-1:0] WIN = `ZDC_PW'(`ZDC_WIN),
    parameter logic [`ZDC_PW-1:0] LO_HMIN = `ZDC_LO_HMIN,
    parameter logic [`ZDC_PW-1:0] LO_HMAX = `ZDC_LO_HMAX,
    parameter logic [`ZDC_PW-1:0] HI_HMIN = `ZDC_HI_HMIN,
    parameter logic [`ZDC_PW-1:0] HI_HMAX = `ZDC_HI_HMAX
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [1:0] output_mode_select,
    input wire logic range_select,
    input wire logic range_select_drv,
    input wire logic freq_double_select,
    input wire logic freq_double_drv,
    input wire logic ref_in,
    input wire logic loop_return_in_p,
    input wire logic loop_return_in_n,
    output logic [NOUT-1:0] q_out_p,
    output logic [NOUT-1:0] q_out_n,
    output logic [NOUT-1:0] q_out_oe,
    output logic loop_drive_out_p,
    output logic loop_drive_out_n,
    output logic loop_drive_out_oe,
    output logic lock_out,
    input wire logic [`ZDC_AW-1:0] reg_addr,
    input wire logic [`ZDC_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`ZDC_DW-1:0] reg_rdata,
    output logic irq
);

    zdc_state_t r_reg;
    zdc_state_t r_next;

    logic fb;
    logic ref_rise;
    logic fb_rise;
    logic pll_on;
    logic hit;
    logic in_band;
    logic [`ZDC_PW-1:0] half;
    logic [`ZDC_PW-1:0] step;
    logic [`ZDC_PW-1:0] sum;
    logic [`ZDC_PW-1:0] cyc;
    logic [`ZDC_PW-1:0] ph;
    logic [`ZDC_EVW-1:0] ev;
    logic [`ZDC_EVW-1:0] w1c;

    // All next-state logic in one place; the struct is registered below.
    always_comb begin
        r_next = r_reg;
        ev = '0;
        w1c = '0;
        // Feedback pair taken as true when the p leg is high and the n leg is low.
        fb = loop_return_in_p & ~loop_return_in_n;
        ref_rise = ref_in & ~r_reg.ref_q;
        fb_rise = fb & ~r_reg.fb_q;
        r_next.ref_q = ref_in;
        r_next.fb_q = fb;
        r_next.sel = output_mode_select;
        // A strap with no driver falls to its pull-down level.
        r_next.range = range_select & range_select_drv;
        r_next.dbl = freq_double_select & freq_double_drv;
        pll_on = (r_reg.sel == `ZDC_SEL_PLL);

        // Reference period in clk cycles, saturating when it stops.
        if (ref_rise) begin
            r_next.per = r_reg.per_cnt + `ZDC_PW'(1);
            r_next.per_cnt = '0;
        end else if (r_reg.per_cnt != '1) begin
            r_next.per_cnt = r_reg.per_cnt + `ZDC_PW'(1);
        end

        // Half period of the generated clock, halved again to double.
        half = r_reg.dbl ? (r_reg.per >> 2) : (r_reg.per >> 1);
        if (half == '0) begin
            half = `ZDC_PW'(1);
        end

        // The loop only locks when the output lands in the chosen band.
        if (r_reg.range) begin
            in_band = (half >= HI_HMIN) && (half <= HI_HMAX);
        end else begin
            in_band = (half >= LO_HMIN) && (half <= LO_HMAX);
        end

        // Generator: a lagging feedback adds a step, a leading one
        // drops a step, so extra feedback delay pulls edges earlier.
        if (r_reg.adv) begin
            step = `ZDC_PW'(2);
        end else if (r_reg.ret) begin
            step = '0;
        end else begin
            step = `ZDC_PW'(1);
        end
        sum = r_reg.gen_cnt + step;
        if (!pll_on) begin
            r_next.gen_cnt = '0;
            r_next.gen_clk = 1'b0;
        end else if (sum >= half) begin
            r_next.gen_cnt = '0;
            r_next.gen_clk = ~r_reg.gen_clk;
        end else begin
            r_next.gen_cnt = sum;
        end

        // Phase detector measured from the last reference edge.
        r_next.adv = 1'b0;
        r_next.ret = 1'b0;
        if (ref_rise) begin
            r_next.ph_cnt = '0;
        end else if (r_reg.ph_cnt != '1) begin
            r_next.ph_cnt = r_reg.ph_cnt + `ZDC_PW'(1);
        end
        // When doubling, every other feedback edge lands mid-period, so
        // the phase is folded onto one output period before it is judged.
        cyc = r_reg.dbl ? (r_reg.per >> 1) : r_reg.per;
        ph = (r_reg.ph_cnt >= cyc) ? (r_reg.ph_cnt - cyc) : r_reg.ph_cnt;
        hit = r_reg.aligned | fb_rise;
        if (ref_rise) begin
            r_next.aligned = 1'b0;
        end else if (fb_rise && pll_on) begin
            if (ph < WIN) begin
                r_next.aligned = 1'b1;
            end else if ((cyc - ph) <= WIN) begin
                r_next.aligned = 1'b1;
            end else if (ph < (cyc >> 1)) begin
                r_next.adv = 1'b1;
            end else begin
                r_next.ret = 1'b1;
            end
        end

        // Count consecutive aligned reference edges.
        if (!pll_on || r_reg.st == ZDC_OFF) begin
            r_next.good = '0;
        end else if (ref_rise) begin
            if (hit && in_band) begin
                if (r_reg.good != LOCK_REFS) begin
                    r_next.good = r_reg.good + `ZDC_GW'(1);
                end
            end else begin
                r_next.good = '0;
            end
        end

        // Loop state; a restart write forces a fresh acquisition.
        unique case (r_reg.st)
            ZDC_OFF: begin
                if (pll_on) begin
                    r_next.st = ZDC_ACQ;
                end
            end
            ZDC_ACQ: begin
                if (!pll_on) begin
                    r_next.st = ZDC_OFF;
                end else if (r_reg.good == LOCK_REFS) begin
                    r_next.st = ZDC_LOCK;
                end
            end
            ZDC_LOCK: begin
                if (!pll_on) begin
                    r_next.st = ZDC_OFF;
                end else if (ref_rise && !(hit && in_band)) begin
                    r_next.st = ZDC_ACQ;
                    r_next.good = '0;
                end
            end
            default: begin
                r_next.st = ZDC_OFF;
            end
        endcase
        if (reg_wr && reg_addr == `ZDC_OFS_CTRL &&
            reg_wdata[`ZDC_CTRL_RESTART] && pll_on) begin
            r_next.st = ZDC_ACQ;
            r_next.good = '0;
        end

        // Lock shows only the locked state, so it is low while
        // acquiring and whenever the loop is shut down.
        r_next.lock = (r_next.st == ZDC_LOCK);

        // Output source per select code; the reserved code is
        // treated as a full shutdown so the pins stay quiet.
        unique case (r_reg.sel)
            `ZDC_SEL_BYPASS: begin
                r_next.oe = 1'b1;
                r_next.q = ref_in;
            end
            `ZDC_SEL_PLL: begin
                r_next.oe = 1'b1;
                r_next.q = r_next.gen_clk;
            end
            `ZDC_SEL_OFF, `ZDC_SEL_RSVD: begin
                r_next.oe = 1'b0;
                r_next.q = 1'b0;
            end
        endcase

        // Events: lock gained, lock lost, reserved code applied.
        ev[`ZDC_EV_LOCK] = r_next.lock & ~r_reg.lock;
        ev[`ZDC_EV_LOSS] = r_reg.lock & ~r_next.lock;
        ev[`ZDC_EV_RSVD] = (output_mode_select == `ZDC_SEL_RSVD) &&
                           (r_reg.sel != `ZDC_SEL_RSVD);

        // Register writes; a new event wins over a same-cycle clear.
        if (reg_wr && reg_addr == `ZDC_OFS_IRQ_STAT) begin
            w1c = reg_wdata[`ZDC_EVW-1:0];
        end
        r_next.stat = (r_reg.stat & ~w1c) | ev;
        if (reg_wr && reg_addr == `ZDC_OFS_IRQ_MASK) begin
            r_next.mask = reg_wdata[`ZDC_EVW-1:0];
        end

        // Read data appear in the cycle after the strobe only.
        r_next.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                `ZDC_OFS_STATUS: begin
                    r_next.rdata[`ZDC_ST_LOCK] = r_reg.lock;
                    r_next.rdata[`ZDC_ST_FSM+:2] = r_reg.st;
                    r_next.rdata[`ZDC_ST_SEL+:2] = r_reg.sel;
                    r_next.rdata[`ZDC_ST_RANGE] = r_reg.range;
                    r_next.rdata[`ZDC_ST_DBL] = r_reg.dbl;
                end
                `ZDC_OFS_IRQ_STAT: begin
                    r_next.rdata[`ZDC_EVW-1:0] = r_reg.stat;
                end
                `ZDC_OFS_IRQ_MASK: begin
                    r_next.rdata[`ZDC_EVW-1:0] = r_reg.mask;
                end
                default: begin
                    r_next.rdata = '0;
                end
            endcase
        end
    end

    // Single state register; clk_en low freezes every field.
    always_ff @(posedge clk) begin
        if (reset) begin
            r_reg <= '0;
            r_reg.st <= ZDC_OFF;
            r_reg.mask <= `ZDC_MASK_RST;
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    // Every output buffer copies the same registered source.
    genvar gi;
    generate
        for (gi = 0; gi < NOUT; gi++) begin : g_out
            assign q_out_p[gi] = r_reg.q;
            assign q_out_n[gi] = ~r_reg.q;
            assign q_out_oe[gi] = r_reg.oe;
        end
    endgenerate

    assign loop_drive_out_p = r_reg.q;
    assign loop_drive_out_n = ~r_reg.q;
    assign loop_drive_out_oe = r_reg.oe;
    assign lock_out = r_reg.lock;
    assign reg_rdata = r_reg.rdata;
    // Level interrupt while any unmasked event bit stands.
    assign irq = |(r_reg.stat & r_reg.mask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_lock_high;
        (r_reg.st == ZDC_LOCK) |-> lock_out;
    endproperty
    a_lock_high: assert property (p_lock_high)
        else $error("lock low while locked");

    property p_lock_entry;
        $rose(lock_out) |-> $past(r_reg.good) == LOCK_REFS;
    endproperty
    a_lock_entry: assert property (p_lock_entry)
        else $error("lock rose without enough aligned edges");

    property p_acq_low;
        (r_reg.st == ZDC_ACQ) |-> !lock_out;
    endproperty
    a_acq_low: assert property (p_acq_low)
        else $error("lock high while acquiring");

    property p_off_low;
        (clk_en && r_reg.sel != `ZDC_SEL_PLL) |=> !lock_out;
    endproperty
    a_off_low: assert property (p_off_low)
        else $error("lock high with loop shut down");

    sequence s_sel_off;
        clk_en && (r_reg.sel == `ZDC_SEL_OFF ||
                   r_reg.sel == `ZDC_SEL_RSVD);
    endsequence
    property p_tristate;
        s_sel_off |=> (q_out_oe == '0) && !loop_drive_out_oe;
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("outputs driven in shutdown code");

    property p_bypass;
        (clk_en && r_reg.sel == `ZDC_SEL_BYPASS) |=>
            q_out_oe[0] && q_out_p[0] == $past(ref_in);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass output does not follow reference");

    property p_pulldown;
        (clk_en && !freq_double_drv && !range_select_drv) |=>
            !r_reg.dbl && !r_reg.range;
    endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("undriven strap not read as low");

    property p_lag_advance;
        r_reg.adv |-> $past(r_reg.sel) == `ZDC_SEL_PLL &&
            $past(ph) >= WIN;
    endproperty
    a_lag_advance: assert property (p_lag_advance)
        else $error("advance step without a lagging feedback");

    property p_set_wins;
        (clk_en && ev[`ZDC_EV_LOCK] && w1c[`ZDC_EV_LOCK]) |=>
            r_reg.stat[`ZDC_EV_LOCK];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost under same-cycle clear");

endmodule // zdc_mode_ctrl

`default_nettype wire

// ### testbench/zdc_board.sv
// Purpose: Board model: free reference source and the feedback trace.
// Assumes: Trace delay counts clk cycles and is set by the bench.
// Notes: A released feedback pair toggles, so no stale level passes.
`timescale 1ns/1ps
`default_nettype none

module zdc_board #(
    parameter int REF_HALF = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] trace_delay,
    input wire logic drive_p,
    input wire logic drive_oe,
    output logic ref_in,
    output logic ret_p,
    output logic ret_n
);
    logic [15:0] trace_reg;
    logic [7:0] ref_cnt;
    logic idle_tog;

    // The reference runs free; the trace is a plain delay line.
    always_ff @(posedge clk) begin
        if (reset) begin
            ref_cnt <= 8'h00;
            ref_in <= 1'b0;
            idle_tog <= 1'b0;
        end else begin
            ref_cnt <= (ref_cnt == 8'(REF_HALF - 1)) ? 8'h00 : ref_cnt + 8'h01;
            ref_in <= (ref_cnt == 8'(REF_HALF - 1)) ? ~ref_in : ref_in;
            idle_tog <= ~idle_tog;
        end
        trace_reg <= {trace_reg[14:0], drive_p};
    end

    // Feedback comes back from an output with the same polarity.
    always_comb begin
        ret_p = drive_oe ? trace_reg[trace_delay] : idle_tog;
        ret_n = ~ret_p;
    end
endmodule // zdc_board

`default_nettype wire

// ### testbench/tb.sv
// Purpose: Self-checking bench of the zero-delay clock mode control.
// Assumes: Reference half period of 8 cycles, lock after 4 edges.
// Notes: Straps change only while the loop is shut down.
`timescale 1ns/1ps
`default_nettype none
`include "zdc_cfg.svh"

module tb;
    typedef struct packed {
        logic [5:0] pins;
        logic oe;
        logic [6:0] st;
    } zdc_row_t;

    logic clk, reset, ref_in, ret_p, ret_n, lock, irq, fb_p, fb_n, fb_oe;
    logic [1:0] mode;
    logic rng, rng_drv, dbl, dbl_drv, reg_wr, reg_rd, r, en;
    logic [3:0] dly;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    logic [9:0] qp, qn, qoe;
    int n_errors, n_tests, t1, t2, k;
    // Pins are {mode, range, range driven, double, double driven}.
    zdc_row_t rows [3] = '{'{6'h0f, 1'b0, 7'h60},
        '{6'h2a, 1'b1, 7'h10}, '{6'h15, 1'b0, 7'h08}};

    zdc_board board (.clk(clk), .reset(reset), .trace_delay(dly),
        .drive_p(fb_p), .drive_oe(fb_oe), .ref_in(ref_in), .ret_p(ret_p),
        .ret_n(ret_n));

    zdc_mode_ctrl #(.LOCK_REFS(8'h04)) dut (.clk(clk), .reset(reset),
        .clk_en(en), .output_mode_select(mode), .range_select(rng),
        .range_select_drv(rng_drv), .freq_double_select(dbl),
        .freq_double_drv(dbl_drv), .ref_in(ref_in),
        .loop_return_in_p(ret_p), .loop_return_in_n(ret_n), .q_out_p(qp),
        .q_out_n(qn), .q_out_oe(qoe), .loop_drive_out_p(fb_p),
        .loop_drive_out_n(fb_n), .loop_drive_out_oe(fb_oe), .lock_out(lock),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .irq(irq));

    task print_verdict;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = rdata;
    endtask

    task straps(input logic [5:0] p);
        @(posedge clk);
        {mode, rng, rng_drv, dbl, dbl_drv} <= p;
    endtask

    // Bounded wait; a lock level that never comes ends the run.
    task wait_lock(input logic want);
        for (k = 0; k < 3000 && lock !== want; k++) begin
            @(posedge clk);
            #1;
        end
        #1 chk("lock_wait", {31'h0, want}, {31'h0, lock});
        if (lock !== want) begin
            print_verdict();
        end
    endtask

    // Cycles until the next rising edge of the reference or output 0.
    task rise(input logic of_q, output int t);
        logic prev, cur;
        prev = of_q ? qp[0] : ref_in;
        for (t = 1; t < 100; t++) begin
            @(posedge clk);
            #1 cur = of_q ? qp[0] : ref_in;
            if (cur === 1'b1 && prev === 1'b0) begin
                break;
            end
            prev = cur;
        end
        // An edge that never comes ends the run as a failure.
        if (t >= 100) begin
            n_errors++;
            print_verdict();
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        {reset, reg_wr, reg_rd, addr, wdata, dly} = {3'h4, 8'h00, 32'h0, 4'h1};
        {mode, rng, rng_drv, dbl, dbl_drv} = 6'h00;
        en = 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        // Table of static modes, pull-downs and the reserved code.
        for (int i = 0; i < 3; i++) begin
            straps(rows[i].pins);
            repeat (4) @(posedge clk);
            #1 chk("oe", {22'h0, {10{rows[i].oe}}}, {22'h0, qoe});
            chk("fb_oe", {31'h0, rows[i].oe}, {31'h0, fb_oe});
            rd(`ZDC_OFS_STATUS, d);
            chk("status", {25'h0, rows[i].st}, d & 32'h7f);
            r = ref_in;
            for (int j = 0; j < 20 && rows[i].oe; j++) begin
                @(posedge clk);
                #1 chk("bypass_q", {31'h0, r}, {31'h0, qp[0]});
                chk("q_n", {22'h0, ~qp}, {22'h0, qn});
                chk("fb_n", {31'h0, ~fb_p}, {31'h0, fb_n});
                r = ref_in;
            end
        end
        rd(`ZDC_OFS_IRQ_STAT, d);
        chk("irq_stat", 32'h4, d);
        wr(`ZDC_OFS_IRQ_STAT, 32'h4);
        rd(`ZDC_OFS_IRQ_STAT, d);
        chk("irq_clear", 32'h0, d);
        rd(8'h10, d);
        chk("unmapped", 32'h0, d);
        rd(`ZDC_OFS_CTRL, d);
        chk("ctrl", 32'h0, d);
        // Acquisition, lock and the output period in loop mode.
        wr(`ZDC_OFS_IRQ_MASK, 32'h1);
        straps(6'h35);
        repeat (10) @(posedge clk);
        #1 chk("lock_acq", 32'h0, {31'h0, lock});
        wait_lock(1'b1);
        rd(`ZDC_OFS_STATUS, d);
        chk("status_lock", 32'h1f, d & 32'h7f);
        chk("irq", 32'h1, {31'h0, irq});
        rise(1'b1, t1);
        rise(1'b1, t1);
        chk("period", 32'd16, 32'(t1));
        // A longer trace must pull the output edges earlier.
        rise(1'b0, t1);
        rise(1'b1, t1);
        @(posedge clk);
        dly <= 4'h6;
        wait_lock(1'b0);
        wait_lock(1'b1);
        rise(1'b0, t2);
        rise(1'b1, t2);
        chk("lead", 32'h1, {31'h0, t2 < t1});
        straps(6'h05);
        repeat (3) @(posedge clk);
        #1 chk("lock_off", 32'h0, {31'h0, lock});
        straps(6'h37);
        wait_lock(1'b1);
        rise(1'b1, t1);
        rise(1'b1, t1);
        chk("period_x2", 32'd8, 32'(t1));
        // Interrupt masked, unmasked and cleared.
        wr(`ZDC_OFS_IRQ_MASK, 32'h0);
        #1 chk("irq_masked", 32'h0, {31'h0, irq});
        wr(`ZDC_OFS_IRQ_MASK, 32'h1);
        #1 chk("irq_on", 32'h1, {31'h0, irq});
        wr(`ZDC_OFS_IRQ_STAT, 32'h7);
        #1 chk("irq_cleared", 32'h0, {31'h0, irq});
        // High band cannot hold this reference, so no lock.
        straps(6'h05);
        straps(6'h3d);
        repeat (400) @(posedge clk);
        #1 chk("lock_band", 32'h0, {31'h0, lock});
        rd(`ZDC_OFS_STATUS, d);
        chk("range_bit", 32'h20, d & 32'h20);
        // Clock enable low must hold the running output still.
        @(posedge clk);
        en <= 1'b0;
        @(posedge clk);
        #1 r = qp[0];
        for (int j = 0; j < 16; j++) begin
            @(posedge clk);
            #1 chk("freeze", {31'h0, r}, {31'h0, qp[0]});
        end
        @(posedge clk);
        en <= 1'b1;
        // Reset in mid-run returns every output to idle.
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("oe_rst", 32'h0, {22'h0, qoe});
        chk("qn_rst", 32'h3ff, {22'h0, qn});
        chk("lock_rst", 32'h0, {30'h0, lock, irq});
        @(posedge clk);
        reset <= 1'b0;
        // Select is latched one edge after release, outputs the next.
        @(posedge clk);
        #1 chk("oe_rel", 32'h0, {22'h0, qoe});
        @(posedge clk);
        #1 chk("oe_on", 32'h3ff, {22'h0, qoe});
        chk("lock_rel", 32'h0, {31'h0, lock});
        print_verdict();
    end
endmodule // tb

`default_nettype wire
